// ===== hdl/pmcr_map.svh
`ifndef PMCR_MAP_SVH
`define PMCR_MAP_SVH
// Clock and timing
`define PMCR_CLK_HZ     100000000
`define PMCR_XTAL_HZ    32768
`define PMCR_RC_HZ      32000
`define PMCR_STEP_MS    2
`define PMCR_SEC_MAX    17'h1517F
// Register byte offsets
`define PMCR_OFS_CTRL   8'h00
`define PMCR_OFS_STATUS 8'h04
`define PMCR_OFS_FLAGS  8'h08
`define PMCR_OFS_SEC    8'h0C
`define PMCR_OFS_DAY    8'h10
`define PMCR_OFS_ASEC   8'h14
`define PMCR_OFS_ADAY   8'h18
`define PMCR_OFS_CUTCFG 8'h1C
`define PMCR_OFS_CUTCNT 8'h20
// Control fields
`define PMCR_CTRL_SECMASK 0
`define PMCR_CTRL_ALMASK  1
`define PMCR_CTRL_HOLD    4
`define PMCR_CTRL_UOFF    5
// Flag fields; bits 2 to 7 are the turn-on sources
`define PMCR_FLG_SEC    0
`define PMCR_FLG_ALARM  1
`define PMCR_FLG_EVT0   2
`define PMCR_FLG_WDOG   8
`define PMCR_FLG_W      9
// Reset values
`define PMCR_RST_CUTCFG 16'h0432
`endif

// ===== hdl/pmcr_pkg.sv
package pmcr_pkg;
  typedef enum logic [2:0] {
    MD_OFF, MD_COLD, MD_ON, MD_HOLD, MD_UOFF, MD_WARM, MD_CUT, MD_SHUTDN
  } pmcr_mode_type;
  typedef struct packed {
    logic [7:0] max_count;
    logic [7:0] max_steps;
  } pmcr_cutcfg_type;
endpackage

// ===== hdl/pmcr_top.sv
// Behaviour
// - Continuous 32.768 kHz square wave output
// - Internal RC oscillator without crystal
// - Slow clock divided to second tick
// - Seconds count 0..86399 then wrap
// - Seconds wrap increments 15-bit day counter
// - Tick sets flag; mask gates interrupt
// - Alarm when seconds and day match
// - Alarm powers up from off, memory hold or user off, else interrupts
// - Off left on turn-on event or on the first cycle after reset release
// - Cold start sequences rails, releases both resets
// - Watchdog low in on mode forces off
// - Memory hold: backups, both resets low
// - User off: backups, system reset low only
// - Warm start sequences rails, releases system reset
// - Power cut backup with duration, count limits
// - Events act only in off, memory hold and user off; own flags
// - Buttons, charger, battery, vbus, alarm turn on
// - Select pins pick sequence and voltage set
// - Rails enabled at 2 ms spacing
`timescale 1ns/10ps
`default_nettype none
`include "pmcr_map.svh"
module pmcr_top import pmcr_pkg::*; #(
  parameter int NUM_RAILS    = 8,
  parameter int STEP_CYCLES  = `PMCR_STEP_MS * (`PMCR_CLK_HZ / 1000),
  parameter int SLOW_PER_SEC = 32768
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  // Wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // Status and event inputs
  input  wire logic                 xtal_present,
  input  wire logic                 main_power_ok,
  input  wire logic                 watchdog_keepalive_in,
  input  wire logic                 button_one_n,
  input  wire logic                 button_two_n,
  input  wire logic                 button_three_n,
  input  wire logic                 charger_input,
  input  wire logic                 battery_node,
  input  wire logic                 vbus_present,
  input  wire logic                 powerup_select_one,
  input  wire logic                 powerup_select_two,
  input  wire logic                 powerup_select_three,
  // Power and reset outputs
  output logic [NUM_RAILS-1:0]      rail_en,
  output logic                      backup_supply_one,
  output logic                      backup_supply_two,
  output logic                      system_reset_n,
  output logic                      processor_reset_n,
  output logic [2:0]                voltage_set,
  // Clocks and interrupt
  output logic                      slow_clock_out,
  output logic                      processor_slow_clock_out,
  output logic                      irq_out
);
  localparam int IDXW = $clog2(NUM_RAILS + 1);
  localparam int STPW = $clog2(STEP_CYCLES + 1);
  localparam int DIVW = $clog2(SLOW_PER_SEC + 1);
  localparam logic [27:0] K_CLK  = 28'(`PMCR_CLK_HZ);
  localparam logic [27:0] K_XINC = 28'(2 * `PMCR_XTAL_HZ);
  localparam logic [27:0] K_RINC = 28'(2 * `PMCR_RC_HZ);

  pmcr_mode_type           mode_r, mode_nxt;
  pmcr_cutcfg_type         cutcfg_r;
  logic [27:0]             acc_r;
  logic                    slow_r;
  logic [DIVW-1:0]         div_r;
  logic [16:0]             sec_r, asec_r;
  logic [14:0]             day_r, aday_r;
  logic [`PMCR_FLG_W-1:0]  flags_r;
  logic                    secmask_r, almask_r, match_prev_r, boot_r;
  logic [5:0]              evt_prev_r;
  logic [STPW-1:0]         step_r;
  logic [IDXW-1:0]         idx_r;
  logic [IDXW-1:0]         idx_nxt;
  logic [7:0]              cutcnt_r;
  logic [2:0]              pums_r;
  logic                    ack_r;
  logic [31:0]             dat_r;
  logic [NUM_RAILS-1:0]    rail_r;
  logic                    sys_r, proc_r, bk_r, pclk_r, irq_r;
  logic [2:0]              vsel_r;

  // Bus decode; every access is acked, unmapped reads give zero
  wire logic        wb_go   = wb_cyc_i & wb_stb_i & ~ack_r;
  wire logic        wb_wr   = wb_go & wb_we_i;
  wire logic        wr_ctrl = wb_wr && wb_adr_i == `PMCR_OFS_CTRL;
  wire logic        wr_flg  = wb_wr && wb_adr_i == `PMCR_OFS_FLAGS;
  wire logic        wr_sec  = wb_wr && wb_adr_i == `PMCR_OFS_SEC;
  wire logic        wr_day  = wb_wr && wb_adr_i == `PMCR_OFS_DAY;
  wire logic        wr_asec = wb_wr && wb_adr_i == `PMCR_OFS_ASEC;
  wire logic        wr_aday = wb_wr && wb_adr_i == `PMCR_OFS_ADAY;
  wire logic        wr_cut  = wb_wr && wb_adr_i == `PMCR_OFS_CUTCFG;
  wire logic [31:0] bmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                               {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire logic [31:0] wdat    = wb_dat_i & bmask;
  wire logic        req_hold = wr_ctrl & wdat[`PMCR_CTRL_HOLD];
  wire logic        req_uoff = wr_ctrl & wdat[`PMCR_CTRL_UOFF];

  // Read mux
  wire logic [31:0] rd_w =
    (wb_adr_i == `PMCR_OFS_CTRL)   ? {30'h0, almask_r, secmask_r} :
    (wb_adr_i == `PMCR_OFS_STATUS) ? {24'h0, xtal_present, pums_r, 1'b0, mode_r} :
    (wb_adr_i == `PMCR_OFS_FLAGS)  ? {23'h0, flags_r} :
    (wb_adr_i == `PMCR_OFS_SEC)    ? {15'h0, sec_r} :
    (wb_adr_i == `PMCR_OFS_DAY)    ? {17'h0, day_r} :
    (wb_adr_i == `PMCR_OFS_ASEC)   ? {15'h0, asec_r} :
    (wb_adr_i == `PMCR_OFS_ADAY)   ? {17'h0, aday_r} :
    (wb_adr_i == `PMCR_OFS_CUTCFG) ? {16'h0, cutcfg_r} :
    (wb_adr_i == `PMCR_OFS_CUTCNT) ? {24'h0, cutcnt_r} : 32'h0;

  // Slow clock by fractional accumulator; RC rate is nominal only
  // Toggles land on ref_clk edges, so each half period jitters by a cycle
  wire logic [27:0] acc_inc  = xtal_present ? K_XINC : K_RINC;
  wire logic [27:0] acc_sum  = acc_r + acc_inc;
  wire logic        half_w   = acc_sum >= K_CLK;
  wire logic        slow_nxt = half_w ? ~slow_r : slow_r;
  wire logic        slow_tick = half_w & ~slow_r;
  wire logic        sec_tick = slow_tick && div_r == DIVW'(SLOW_PER_SEC - 1);
  wire logic        sec_wrap = sec_tick && sec_r == `PMCR_SEC_MAX;

  // Alarm fires once on entering the match
  wire logic        match_w  = sec_r == asec_r && day_r == aday_r;
  wire logic        alarm_w  = match_w & ~match_prev_r;

  // Turn-on sources, active high, caught on their edge
  wire logic [5:0]  evt_lvl  = {vbus_present, battery_node, charger_input,
                                ~button_three_n, ~button_two_n, ~button_one_n};
  wire logic [5:0]  evt_rise = evt_lvl & ~evt_prev_r;
  wire logic        turn_on  = (|evt_rise) | alarm_w;

  // Sticky flags; a set in the clearing cycle wins
  wire logic        wdog_w   = mode_r == MD_ON && !watchdog_keepalive_in && main_power_ok;
  wire logic [`PMCR_FLG_W-1:0] flg_set = {wdog_w, evt_rise, alarm_w, sec_tick};
  wire logic [`PMCR_FLG_W-1:0] flg_clr = wr_flg ? wdat[`PMCR_FLG_W-1:0] : '0;
  wire logic [`PMCR_FLG_W-1:0] flags_nxt = (flags_r & ~flg_clr) | flg_set;
  wire logic [`PMCR_FLG_W-1:0] irq_en = {{(`PMCR_FLG_W-2){1'b1}}, ~almask_r, ~secmask_r};

  // Sequencer timing
  wire logic        seq_mode  = mode_r == MD_COLD || mode_r == MD_WARM;
  wire logic        step_done = step_r == STPW'(STEP_CYCLES - 1);

  // Power cut runs out on its count or on its duration
  wire logic        cut_over  = cutcnt_r > cutcfg_r.max_count ||
                                idx_r >= IDXW'(NUM_RAILS) && step_done &&
                                cutcfg_r.max_steps == 8'h00;
  logic [7:0]       cutdur_r;
  wire logic        cut_expire = cutdur_r >= cutcfg_r.max_steps || cut_over;

  // Power-up select: sequence and voltage set from the three pins
  wire logic [1:0]  pums_seq = 2'(pums_r % 3'h3);
  wire logic [2:0]  pums_vs  = 3'(pums_r % 3'h5);

  // Rail order per selected sequence
  logic [NUM_RAILS-1:0] rail_seq_w;
  for (genvar g = 0; g < NUM_RAILS; g++) begin : g_rail
    // Position of this rail in each of the three orders
    localparam logic [IDXW-1:0] P0 = IDXW'(g);
    localparam logic [IDXW-1:0] P1 = IDXW'(NUM_RAILS - 1 - g);
    localparam logic [IDXW-1:0] P2 = IDXW'((g + NUM_RAILS / 2) % NUM_RAILS);
    wire logic [IDXW-1:0] pos = (pums_seq == 2'h0) ? P0 : (pums_seq == 2'h1) ? P1 : P2;
    assign rail_seq_w[g] = pos < idx_nxt;
  end

  // Mode transitions
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      MD_OFF: begin
        if (boot_r || turn_on) mode_nxt = MD_COLD;
      end
      MD_COLD, MD_WARM: begin
        if (!main_power_ok) mode_nxt = MD_CUT;
        else if (step_done && idx_r == IDXW'(NUM_RAILS)) mode_nxt = MD_ON;
      end
      MD_ON: begin
        if (!main_power_ok) mode_nxt = MD_CUT;
        else if (!watchdog_keepalive_in) mode_nxt = MD_SHUTDN;
        else if (req_hold) mode_nxt = MD_HOLD;
        else if (req_uoff) mode_nxt = MD_UOFF;
      end
      MD_HOLD: begin
        if (!main_power_ok) mode_nxt = MD_CUT;
        else if (turn_on) mode_nxt = MD_COLD;
      end
      MD_UOFF: begin
        if (!main_power_ok) mode_nxt = MD_CUT;
        else if (turn_on) mode_nxt = MD_WARM;
      end
      MD_CUT: begin
        if (main_power_ok) mode_nxt = MD_COLD;
        else if (cut_expire) mode_nxt = MD_OFF;
      end
      MD_SHUTDN: mode_nxt = MD_OFF;
      default: mode_nxt = MD_OFF;
    endcase
  end

  // Outputs follow the next mode so they line up with mode_r
  wire logic nx_on   = mode_nxt == MD_ON;
  wire logic nx_seq  = mode_nxt == MD_COLD || mode_nxt == MD_WARM;
  wire logic sys_nxt = nx_on;
  wire logic proc_nxt = nx_on || mode_nxt == MD_UOFF || mode_nxt == MD_WARM;
  wire logic [NUM_RAILS-1:0] rail_nxt = nx_on ? '1 : nx_seq ? rail_seq_w :
                                        (mode_nxt == MD_SHUTDN) ? rail_r : '0;
  wire logic pclk_on = nx_on || nx_seq || mode_nxt == MD_UOFF;

  // Rail index; rails follow the next index so a rail lands on its step edge
  assign idx_nxt = !nx_seq || mode_nxt != mode_r ? '0 :
                   (step_done && idx_r < IDXW'(NUM_RAILS)) ? IDXW'(idx_r + 1'b1) : idx_r;

  // Bus slave: one-cycle answer, ack drops the cycle after
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= wb_go;
      dat_r <= wb_go ? rd_w : dat_r;
    end
  end

  // Slow clock, second divider
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_r  <= 28'h0;
      slow_r <= 1'b0;
      div_r  <= '0;
    end else begin
      acc_r  <= half_w ? 28'(acc_sum - K_CLK) : acc_sum;
      slow_r <= slow_nxt;
      div_r  <= sec_tick ? '0 : slow_tick ? DIVW'(div_r + 1'b1) : div_r;
    end
  end

  // Time and day counters; a write takes precedence over the tick
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sec_r <= 17'h0;
      day_r <= 15'h0;
    end else begin
      if (wr_sec) sec_r <= wdat[16:0];
      else if (sec_tick) sec_r <= sec_wrap ? 17'h0 : 17'(sec_r + 1'b1);
      if (wr_day) day_r <= wdat[14:0];
      else if (sec_wrap) day_r <= 15'(day_r + 1'b1);
    end
  end

  // Software registers and flags
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      asec_r    <= 17'h0;
      aday_r    <= 15'h7FFF;
      secmask_r <= 1'b1;
      almask_r  <= 1'b1;
      cutcfg_r  <= `PMCR_RST_CUTCFG;
      flags_r   <= '0;
      match_prev_r <= 1'b1;
      evt_prev_r   <= 6'h00;
    end else begin
      asec_r    <= wr_asec ? wdat[16:0] : asec_r;
      aday_r    <= wr_aday ? wdat[14:0] : aday_r;
      secmask_r <= wr_ctrl ? wdat[`PMCR_CTRL_SECMASK] : secmask_r;
      almask_r  <= wr_ctrl ? wdat[`PMCR_CTRL_ALMASK] : almask_r;
      cutcfg_r  <= wr_cut ? wdat[15:0] : cutcfg_r;
      flags_r   <= flags_nxt;
      match_prev_r <= match_w;
      evt_prev_r   <= evt_lvl;
    end
  end

  // Mode, step timer and power-cut bookkeeping
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_r   <= MD_OFF;
      boot_r   <= 1'b1;
      pums_r   <= 3'h0;
      step_r   <= '0;
      idx_r    <= '0;
      cutcnt_r <= 8'h00;
      cutdur_r <= 8'h00;
    end else begin
      mode_r <= mode_nxt;
      boot_r <= 1'b0;
      // Pins caught one edge after release, never under reset
      if (boot_r) pums_r <= {powerup_select_three, powerup_select_two, powerup_select_one};
      step_r <= (mode_nxt != mode_r || step_done) ? '0 :
                (seq_mode || mode_r == MD_CUT) ? STPW'(step_r + 1'b1) : '0;
      idx_r  <= idx_nxt;
      if (mode_nxt == MD_OFF) cutcnt_r <= 8'h00;
      else if (mode_nxt == MD_CUT && mode_r != MD_CUT && cutcnt_r != 8'hFF)
        cutcnt_r <= 8'(cutcnt_r + 1'b1);
      cutdur_r <= mode_r != MD_CUT ? 8'h00 :
                  (step_done && cutdur_r != 8'hFF) ? 8'(cutdur_r + 1'b1) : cutdur_r;
    end
  end

  // Pin outputs, all registered
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rail_r <= '0;
      sys_r  <= 1'b0;
      proc_r <= 1'b0;
      bk_r   <= 1'b0;
      pclk_r <= 1'b0;
      irq_r  <= 1'b0;
      vsel_r <= 3'h0;
    end else begin
      rail_r <= rail_nxt;
      sys_r  <= sys_nxt;
      proc_r <= proc_nxt;
      bk_r   <= mode_nxt != MD_OFF;
      pclk_r <= slow_nxt & pclk_on;
      irq_r  <= |(flags_nxt & irq_en);
      vsel_r <= pums_vs;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign rail_en = rail_r;
  assign backup_supply_one = bk_r;
  assign backup_supply_two = bk_r;
  assign system_reset_n = sys_r;
  assign processor_reset_n = proc_r;
  assign voltage_set = vsel_r;
  assign slow_clock_out = slow_r;
  assign processor_slow_clock_out = pclk_r;
  assign irq_out = irq_r;


  // Checks on counters, flags and mode outputs; masked during reset
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sec_wrap_a: assert property (sec_wrap && !wr_sec |=> sec_r == 17'h0)
    else $error("seconds did not wrap");
  day_step_a: assert property (sec_wrap && !wr_day |=> day_r == 15'($past(day_r) + 1'b1))
    else $error("day did not advance");
  sec_irq_a: assert property (sec_tick && !secmask_r && !wr_ctrl |=> flags_r[0] && irq_r)
    else $error("second interrupt missing");
  alarm_flag_a: assert property (alarm_w |=> flags_r[`PMCR_FLG_ALARM])
    else $error("alarm flag missing");
  wdog_off_a: assert property (mode_r == MD_ON && main_power_ok && !watchdog_keepalive_in
    |=> !sys_r && !proc_r && rail_r == $past(rail_r) ##1 mode_r == MD_OFF)
    else $error("watchdog shutdown order wrong");
  hold_pins_a: assert property (mode_r == MD_HOLD |-> !sys_r && !proc_r && rail_r == '0
    && bk_r)
    else $error("memory hold outputs wrong");
  uoff_pins_a: assert property (mode_r == MD_UOFF |-> !sys_r && proc_r && rail_r == '0)
    else $error("user off outputs wrong");
  rail_hold_a: assert property (seq_mode && $stable(mode_r) && !step_done && main_power_ok
    && mode_nxt == mode_r |=> $stable(rail_r))
    else $error("rail changed between steps");
  on_gate_a: assert property (mode_r == MD_ON && main_power_ok && watchdog_keepalive_in
    && !req_hold && !req_uoff |=> mode_r == MD_ON)
    else $error("turn-on event acted in on mode");
endmodule
`default_nettype wire

// ===== test/pmcr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module pmcr_host_model (
  // Bench control
  input  wire logic stop_kick,
  // Device side
  input  wire logic processor_reset_n,
  output logic      watchdog_keepalive_in
);
  // Board pull-up holds the line while the host is in reset
  assign watchdog_keepalive_in = !(stop_kick && processor_reset_n);
endmodule
`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int STEP = 20;
  // Bench driven signals
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic        xtal_present = 1'b1;
  logic        main_power_ok = 1'b1;
  logic        button_one_n = 1'b1;
  logic        button_two_n = 1'b1;
  logic        button_three_n = 1'b1;
  logic        charger_input = 1'b0;
  logic        battery_node = 1'b0;
  logic        vbus_present = 1'b0;
  logic [2:0]  pu = 3'h0;
  logic        stop_kick = 1'b0;
  // Design and host model outputs
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        watchdog_keepalive_in;
  logic [7:0]  rail_en;
  logic        backup_supply_one;
  logic        backup_supply_two;
  logic        system_reset_n;
  logic        processor_reset_n;
  logic [2:0]  voltage_set;
  logic        slow_clock_out;
  logic        processor_slow_clock_out;
  logic        irq_out;
  // Bookkeeping
  logic [63:0] q[$];
  logic [63:0] e;
  logic [31:0] rs = 32'h1C55;
  logic [31:0] r;
  int          num_errors = 0;
  int          checks = 0;
  int          cyc_n = 0;

  always #5 ref_clk = ~ref_clk;

  pmcr_top #(.STEP_CYCLES(STEP), .SLOW_PER_SEC(4)) u_pmcr_top (
    .ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .xtal_present, .main_power_ok,
    .watchdog_keepalive_in, .button_one_n, .button_two_n,
    .button_three_n, .charger_input, .battery_node, .vbus_present,
    .powerup_select_one(pu[0]), .powerup_select_two(pu[1]), .powerup_select_three(pu[2]),
    .rail_en, .backup_supply_one, .backup_supply_two, .system_reset_n,
    .processor_reset_n, .voltage_set, .slow_clock_out,
    .processor_slow_clock_out, .irq_out
  );

  pmcr_host_model u_pmcr_host_model (
    .stop_kick, .processor_reset_n, .watchdog_keepalive_in
  );

  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  task automatic conclude();
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    checks = checks + 1;
    if (g !== x) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
      num_errors = num_errors + 1;
    end
  endtask

  // Settle a little after the edge so registered outputs have landed
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // One classic cycle; for reads d is the expected value under mask m
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] m);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    if (!we) q.push_back({m, d});
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // Start-up walk: rail spacing, then reset release one step after
  task automatic start_chk(input logic warm);
    int n;
    n = 0;
    while (rail_en === 8'h00) tick(1);
    cmp({system_reset_n, processor_reset_n}, {1'b0, warm});
    while (rail_en !== 8'hFF) begin
      tick(1);
      n++;
    end
    cmp(n, 7 * STEP);
    n = 0;
    while (system_reset_n !== 1'b1) begin
      tick(1);
      n++;
    end
    cmp(n, STEP);
    cmp({processor_reset_n, rail_en}, 9'h1FF);
  endtask

  // Slow clock period in ref cycles, jitter of a cycle or two allowed
  task automatic per(input int lo, input int hi);
    int n;
    n = 0;
    while (slow_clock_out !== 1'b0) tick(1);
    while (slow_clock_out !== 1'b1) tick(1);
    while (slow_clock_out !== 1'b0) begin
      tick(1);
      n++;
    end
    while (slow_clock_out !== 1'b1) begin
      tick(1);
      n++;
    end
    cmp(n >= lo && n <= hi, 1'b1);
  endtask

  // Hang guard, well above the longest expected run
  always @(posedge ref_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 90000) begin
      num_errors = num_errors + 1;
      conclude();
    end
  end

  // Read results are judged against the oldest note
  always @(posedge ref_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && q.size() > 0) begin
      e = q.pop_front();
      cmp(wb_dat_o & e[63:32], e[31:0]);
    end
  end

  initial begin
    repeat (15) @(posedge ref_clk);
    #1 cmp({system_reset_n, processor_reset_n, rail_en}, 10'h0);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    r = xs();
    pu <= r[31:29];
    start_chk(1'b0);
    cmp(voltage_set, 3'(pu % 3'h5));
    wb(0, 8'h00, 32'h3, 32'h3);
    wb(0, 8'h18, 32'h7FFF, 32'h7FFF);
    wb(0, 8'h1C, 32'h432, 32'hFFFF);
    wb(0, 8'h40, 32'h0, 32'hFFFFFFFF);
    wb(0, 8'h04, {24'h0, 1'b1, pu, 4'h2}, 32'hF7);
    per(3050, 3054);
    @(posedge ref_clk) xtal_present <= 1'b0;
    per(3123, 3127);
    @(posedge ref_clk) xtal_present <= 1'b1;
    // Seconds wrap into the day count
    wb(1, 8'h08, 32'h1FF, 0);
    wb(1, 8'h00, 32'h0, 0);
    while (irq_out !== 1'b1) tick(1);
    wb(1, 8'h0C, 32'h1517F, 0);
    wb(1, 8'h10, 32'h5, 0);
    wb(1, 8'h08, 32'h1FF, 0);
    tick(2);
    cmp(irq_out, 1'b0);
    while (irq_out !== 1'b1) tick(1);
    wb(0, 8'h10, 32'h6, 32'h7FFF);
    wb(0, 8'h0C, 32'h0, 32'h1FFFF);
    wb(0, 8'h10, 32'h6, 32'h7FFF);
    r = xs();
    wb(1, 8'h14, r, 0);
    wb(0, 8'h14, r & 32'h1FFFF, 32'h1FFFF);
    // Alarm while on only interrupts
    wb(1, 8'h14, 32'h1, 0);
    wb(1, 8'h18, 32'h6, 0);
    wb(1, 8'h08, 32'h1FF, 0);
    while (irq_out !== 1'b1) tick(1);
    tick(3);
    wb(0, 8'h08, 32'h3, 32'h3);
    wb(0, 8'h04, 32'h2, 32'h7);
    // Masked second tick keeps the line quiet
    wb(1, 8'h00, 32'h3, 0);
    wb(1, 8'h08, 32'h1FF, 0);
    tick(13000);
    cmp(irq_out, 1'b0);
    wb(0, 8'h08, 32'h1, 32'h1);
    // Event in on mode only flags
    @(posedge ref_clk) begin
      battery_node <= 1'b1;
      button_two_n <= 1'b0;
      button_three_n <= 1'b0;
    end
    tick(3);
    wb(0, 8'h08, 32'h58, 32'h58);
    wb(0, 8'h04, 32'h2, 32'h7);
    // Watchdog failure
    @(posedge ref_clk) stop_kick <= 1'b1;
    while (system_reset_n !== 1'b0) tick(1);
    cmp({processor_reset_n, rail_en}, 9'h0FF);
    tick(1);
    cmp({backup_supply_one, rail_en}, 9'h0);
    @(posedge ref_clk) stop_kick <= 1'b0;
    tick(50);
    cmp({processor_slow_clock_out, rail_en}, 9'h0);
    wb(0, 8'h04, 32'h0, 32'h7);
    wb(0, 8'h08, 32'h100, 32'h100);
    @(posedge ref_clk) button_one_n <= 1'b0;
    start_chk(1'b0);
    wb(0, 8'h08, 32'h4, 32'h4);
    // User off, then warm start on charger
    wb(1, 8'h00, 32'h23, 0);
    tick(3);
    cmp({system_reset_n, processor_reset_n, backup_supply_one, backup_supply_two, rail_en},
        12'h700);
    while (processor_slow_clock_out !== 1'b1) tick(1);
    @(posedge ref_clk) charger_input <= 1'b1;
    start_chk(1'b1);
    // Memory hold, then cold start on vbus
    wb(1, 8'h00, 32'h13, 0);
    tick(3);
    cmp({system_reset_n, processor_reset_n, backup_supply_one, backup_supply_two, rail_en},
        12'h300);
    cmp(processor_slow_clock_out, 1'b0);
    @(posedge ref_clk) vbus_present <= 1'b1;
    start_chk(1'b0);
    // Short power cut and return
    @(posedge ref_clk) main_power_ok <= 1'b0;
    tick(3);
    cmp({backup_supply_one, backup_supply_two}, 2'b11);
    wb(0, 8'h04, 32'h6, 32'h7);
    @(posedge ref_clk) main_power_ok <= 1'b1;
    start_chk(1'b0);
    wb(0, 8'h20, 32'h1, 32'hFF);
    // Alarm as turn-on event from off
    @(posedge ref_clk) stop_kick <= 1'b1;
    while (rail_en !== 8'h00) tick(1);
    @(posedge ref_clk) stop_kick <= 1'b0;
    wb(1, 8'h0C, 32'h1, 0);
    start_chk(1'b0);
    wb(0, 8'h08, 32'h2, 32'h2);
    tick(2);
    conclude();
  end
endmodule
`default_nettype wire
